// ---- src/dwp_watch.sv ----
`timescale 1ns/1ps
// Function
// - four 32-bit first-address registers at indices 0x50 to 0x53.
// - four 32-bit second-address registers at indices 0x60 to 0x63.
// - four data control registers at 0x70 to 0x73, fields reset to 0.
// - a data watchpoint fires only if enabled and its thread bit is set.
// - control bit 2 makes a data watchpoint fire on loads.
// - control bit 1 picks A and B (0) or A or B (1).
// - four 32-bit resource mask registers at indices 0x80 to 0x83.
// - four 32-bit resource value registers at indices 0x90 to 0x93.
// - four resource control registers at 0x9C to 0x9F, reset to 0.
// - resource control bit 1 picks match (0) or mismatch (1).
// - a resource watchpoint fires only if enabled and thread bit set.
// - a hit records cause 4 for data or 5 for resource.
// - a data hit captures the access effective address.
// - a resource hit captures the resource identifier.
// - the firing watchpoint number is recorded, lowest wins.
////////////////////////////////////////////////////////////////////////////
module dwp_watch #(
    parameter int NUM_WP = 4,
    parameter int NUM_THR = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic memValid,
    input wire logic memIsLoad,
    input wire logic [2:0] memThread,
    input wire logic [31:0] memAddr,
    input wire logic resValid,
    input wire logic [2:0] resThread,
    input wire logic [31:0] resId,
    output logic debugHit,
    output logic irq
);
    import dwp_pkg::*;

    // the priority encoder and thread select are written for these sizes
    if (NUM_WP != 4 || NUM_THR != 8) begin : g_sizeCheck
        $error("dwp_watch supports four watchpoints and eight threads");
    end

    logic [31:0] dAddrA_q [NUM_WP];
    logic [31:0] dAddrB_q [NUM_WP];
    logic [31:0] dCtrl_q [NUM_WP];
    logic [31:0] rMask_q [NUM_WP];
    logic [31:0] rValue_q [NUM_WP];
    logic [31:0] rCtrl_q [NUM_WP];
    logic [31:0] cause_q;
    logic [31:0] causeData_q;
    logic [1:0] irqStatus_q;
    logic [1:0] irqMask_q;

    ////////////////////////////////////////////////////////////////////////
    // apb decode; writes take no wait state, reads take one so that prdata
    // comes straight from a flop; unmapped addresses answer pslverr
    logic access;
    logic wrEn;
    logic rdFirst;
    logic rdWait_q;
    logic [7:0] idx;
    logic mapped;
    logic [31:0] rdMux;

    // word aligned and inside the debug register window
    function automatic logic inWindow(input logic [11:0] a);
        inWindow = (a[1:0] == 2'h0) && (a[11:10] == 2'h0);
    endfunction

    // one group of four consecutive indices, one per watchpoint
    function automatic logic inGroup(input logic [7:0] i, input logic [7:0] b);
        inGroup = (i >= b) && (i < b + 8'h04);
    endfunction

    assign access = psel && penable;
    assign wrEn = access && pwrite && inWindow(paddr);
    assign rdFirst = access && !pwrite && !rdWait_q;
    assign idx = paddr[9:2];
    // a read costs one extra cycle; in exchange no mux path reaches prdata
    assign pready = !access || pwrite || rdWait_q;

    always_comb begin
        mapped = 1'b1;
        rdMux = 32'h00000000;
        if (!inWindow(paddr)) begin
            mapped = 1'b0;
        end else if (inGroup(idx, IDX_DADDR_A)) begin
            rdMux = dAddrA_q[idx[1:0]];
        end else if (inGroup(idx, IDX_DADDR_B)) begin
            rdMux = dAddrB_q[idx[1:0]];
        end else if (inGroup(idx, IDX_DCTRL)) begin
            rdMux = dCtrl_q[idx[1:0]];
        end else if (inGroup(idx, IDX_RMASK)) begin
            rdMux = rMask_q[idx[1:0]];
        end else if (inGroup(idx, IDX_RVALUE)) begin
            rdMux = rValue_q[idx[1:0]];
        end else if (inGroup(idx, IDX_RCTRL)) begin
            rdMux = rCtrl_q[idx[1:0]];
        end else if (idx == IDX_CAUSE) begin
            rdMux = cause_q;
        end else if (idx == IDX_CDATA) begin
            rdMux = causeData_q;
        end else if (idx == IDX_IRQ_STATUS) begin
            rdMux = {30'h00000000, irqStatus_q};
        end else if (idx == IDX_IRQ_MASK) begin
            rdMux = {30'h00000000, irqMask_q};
        end else begin
            mapped = 1'b0;
        end
    end

    assign pslverr = access && !mapped;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
        end else if (rdFirst) begin
            prdata <= rdMux;
        end
    end

    // the wait flag lives for exactly one cycle of each read access
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdWait_q <= 1'b0;
        end else begin
            rdWait_q <= rdFirst;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // watchpoint registers, one process per register file; addresses have
    // no defined reset value, zero keeps them from matching unknowns
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_WP; i++) begin
                dAddrA_q[i] <= 32'h00000000;
            end
        end else if (wrEn && inGroup(idx, IDX_DADDR_A)) begin
            dAddrA_q[idx[1:0]] <= pwdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_WP; i++) begin
                dAddrB_q[i] <= 32'h00000000;
            end
        end else if (wrEn && inGroup(idx, IDX_DADDR_B)) begin
            dAddrB_q[idx[1:0]] <= pwdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_WP; i++) begin
                dCtrl_q[i] <= CTRL_RESET;
            end
        end else if (wrEn && inGroup(idx, IDX_DCTRL)) begin
            dCtrl_q[idx[1:0]] <= pwdata & DCTRL_WMASK;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_WP; i++) begin
                rMask_q[i] <= 32'h00000000;
            end
        end else if (wrEn && inGroup(idx, IDX_RMASK)) begin
            rMask_q[idx[1:0]] <= pwdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_WP; i++) begin
                rValue_q[i] <= 32'h00000000;
            end
        end else if (wrEn && inGroup(idx, IDX_RVALUE)) begin
            rValue_q[idx[1:0]] <= pwdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_WP; i++) begin
                rCtrl_q[i] <= CTRL_RESET;
            end
        end else if (wrEn && inGroup(idx, IDX_RCTRL)) begin
            rCtrl_q[idx[1:0]] <= pwdata & RCTRL_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // match logic
    logic [NUM_WP-1:0] dHit;
    logic [NUM_WP-1:0] rHit;

    function automatic logic thrOk(input logic [31:0] c, input logic [2:0] t);
        thrOk = c[CTL_EN_BIT] && c[CTL_THR_LSB + int'(t)];
    endfunction

    function automatic logic [1:0] lowest(input logic [3:0] v);
        if (v[0]) begin
            lowest = 2'd0;
        end else if (v[1]) begin
            lowest = 2'd1;
        end else if (v[2]) begin
            lowest = 2'd2;
        end else begin
            lowest = 2'd3;
        end
    endfunction

    always_comb begin
        for (int i = 0; i < NUM_WP; i++) begin
            logic condA;
            logic condB;
            logic kindOk;
            logic rMatch;
            condA = memAddr == dAddrA_q[i];
            condB = memAddr == dAddrB_q[i];
            // load bit set: loads; clear: stores
            kindOk = dCtrl_q[i][CTL_LOAD_BIT] == memIsLoad;
            dHit[i] = memValid && kindOk && thrOk(dCtrl_q[i], memThread) &&
                (dCtrl_q[i][CTL_MODE_BIT] ? (condA || condB)
                                          : (condA && condB));
            rMatch = (resId & rMask_q[i]) == rValue_q[i];
            rHit[i] = resValid && thrOk(rCtrl_q[i], resThread) &&
                (rCtrl_q[i][CTL_MODE_BIT] ? !rMatch : rMatch);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cause capture; data hits take priority over resource hits in one cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cause_q <= 32'h00000000;
            causeData_q <= 32'h00000000;
        end else begin
            if (|dHit) begin
                cause_q <= {14'h0000, lowest(dHit), 5'h00, memThread,
                    5'h00, CAUSE_DATA};
                causeData_q <= memAddr;
            end else if (|rHit) begin
                cause_q <= {14'h0000, lowest(rHit), 5'h00, resThread,
                    5'h00, CAUSE_RES};
                causeData_q <= resId;
            end
        end
    end

    // one-cycle pulse to the core for any hit of this cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            debugHit <= 1'b0;
        end else begin
            debugHit <= |dHit || |rHit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status, write one to clear; a new hit wins over the clear so
    // that an event landing with the clear is never lost
    logic [1:0] irqClr;
    logic [1:0] irqSet;

    assign irqClr = (wrEn && idx == IDX_IRQ_STATUS) ? pwdata[1:0] : 2'h0;

    always_comb begin
        irqSet = 2'h0;
        irqSet[IRQ_DATA_BIT] = |dHit;
        irqSet[IRQ_RES_BIT] = |rHit;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irqStatus_q <= 2'h0;
        end else begin
            irqStatus_q <= (irqStatus_q & ~irqClr) | irqSet;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irqMask_q <= 2'h0;
        end else if (wrEn && idx == IDX_IRQ_MASK) begin
            irqMask_q <= pwdata[1:0];
        end
    end

    assign irq = |(irqStatus_q & irqMask_q);
endmodule

// ---- shared/dwp_pkg.sv ----
package dwp_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_DADDR_A = 8'h50;
    localparam logic [7:0] IDX_DADDR_B = 8'h60;
    localparam logic [7:0] IDX_DCTRL = 8'h70;
    localparam logic [7:0] IDX_RMASK = 8'h80;
    localparam logic [7:0] IDX_RVALUE = 8'h90;
    localparam logic [7:0] IDX_RCTRL = 8'h9C;
    localparam logic [7:0] IDX_CAUSE = 8'h15;
    localparam logic [7:0] IDX_CDATA = 8'h16;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hA0;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hA1;
    // control fields
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_MODE_BIT = 1;
    localparam int CTL_LOAD_BIT = 2;
    localparam int CTL_THR_LSB = 16;
    localparam int CTL_THR_MSB = 23;
    localparam logic [31:0] DCTRL_WMASK = 32'h00FF0007;
    localparam logic [31:0] RCTRL_WMASK = 32'h00FF0003;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    // cause record
    localparam logic [2:0] CAUSE_DATA = 3'h4;
    localparam logic [2:0] CAUSE_RES = 3'h5;
    localparam int CAUSE_THR_LSB = 8;
    localparam int CAUSE_WP_LSB = 16;
    // interrupt status bits
    localparam int IRQ_DATA_BIT = 0;
    localparam int IRQ_RES_BIT = 1;
endpackage

// ---- verif/dwp_checker.sv ----
`timescale 1ns/1ps
module dwp_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic memValid,
    input wire logic resValid,
    input wire logic debugHit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic acc;
    logic [7:0] blk;
    assign acc = psel && penable && paddr[1:0] == 2'b00;
    assign blk = paddr[11:4];
    property p_addrA; acc && blk == 8'h14 |-> !pslverr; endproperty
    a_addrA: assert property (p_addrA) else $error("map");
    property p_addrB; acc && blk == 8'h18 |-> !pslverr; endproperty
    a_addrB: assert property (p_addrB) else $error("map");
    property p_dctl; acc && blk == 8'h1C |-> !pslverr; endproperty
    a_dctl: assert property (p_dctl) else $error("map");
    property p_mask; acc && blk == 8'h20 |-> !pslverr; endproperty
    a_mask: assert property (p_mask) else $error("map");
    property p_val; acc && blk == 8'h24 |-> !pslverr; endproperty
    a_val: assert property (p_val) else $error("map");
    property p_rctl; acc && blk == 8'h27 |-> !pslverr; endproperty
    a_rctl: assert property (p_rctl) else $error("map");
    property p_cause; acc && paddr == 12'h054 |-> !pslverr; endproperty
    a_cause: assert property (p_cause) else $error("map");
    property p_data; acc && paddr == 12'h058 |-> !pslverr; endproperty
    a_data: assert property (p_data) else $error("map");
    // writes complete in their first access cycle
    property p_wrReady; psel && penable && pwrite |-> pready; endproperty
    a_wrReady: assert property (p_wrReady) else $error("wait");
    // reads hold pready low in the first access cycle for the data flop
    property p_rdWait;
        psel && penable && !pwrite && pready |-> $past(psel && penable);
    endproperty
    a_rdWait: assert property (p_rdWait) else $error("wait");
    // a hit needs an operation one cycle earlier
    property p_hit; debugHit |-> $past(memValid || resValid); endproperty
    a_hit: assert property (p_hit) else $error("hit");
endmodule
////////////////////////////////////////////////////////////////////////////
bind dwp_watch dwp_checker u_chk (.clk, .resetn, .psel, .penable, .pwrite,
    .paddr, .pready, .pslverr, .memValid, .resValid, .debugHit);

// ---- verif/dwp_core_model.sv ----
`timescale 1ns/1ps
module dwp_core_model (
    input wire logic clk,
    output logic memValid,
    output logic memIsLoad,
    output logic [2:0] memThread,
    output logic [31:0] memAddr,
    output logic resValid,
    output logic [2:0] resThread,
    output logic [31:0] resId
);
    // idle buses show the inverse, so a stale operand cannot match
    initial begin
        {memValid, memIsLoad, resValid} = 3'h0;
        {memThread, resThread} = 6'h3F;
        {memAddr, resId} = {2{32'hFFFFFFFF}};
    end
    task automatic memOp(input logic ld, input logic [2:0] t,
        input logic [31:0] a);
        {memValid, memIsLoad, memThread, memAddr} <= {1'b1, ld, t, a};
        @(posedge clk);
        {memValid, memThread, memAddr} <= {1'b0, ~t, ~a};
    endtask
    task automatic resOp(input logic [2:0] t, input logic [31:0] d);
        {resValid, resThread, resId} <= {1'b1, t, d};
        @(posedge clk);
        {resValid, resThread, resId} <= {1'b0, ~t, ~d};
    endtask
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
    import dwp_pkg::*;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, debugHit, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, memAddr, resId;
    logic memValid, memIsLoad, resValid;
    logic [2:0] memThread, resThread;
    int n_errors = 0;
    int num_checks = 0;
    dwp_watch dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .memValid, .memIsLoad, .memThread,
        .memAddr, .resValid, .resThread, .resId, .debugHit, .irq);
    dwp_core_model core (.clk, .memValid, .memIsLoad, .memThread, .memAddr,
        .resValid, .resThread, .resId);
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    // debugHit stands for one cycle; look at it mid-cycle, then realign
    task automatic chkHit(input logic e);
        @(negedge clk);
        chk({31'h0, debugHit}, {31'h0, e});
        @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic er);
        int n;
        logic rdy;
        n = 0;
        rdy = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // what stands mid-cycle is what the next rising edge takes
        do begin
            @(negedge clk);
            rdy = pready;
            er = pslverr;
            r = prdata;
            n++;
            @(posedge clk);
        end while (rdy !== 1'b1 && n < 50);
        if (rdy !== 1'b1) begin
            chk(32'h0, 32'h1);
            give_verdict;
        end
        {psel, penable} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [11:0] b[4] = '{12'h14C, 12'h18C, 12'h20C, 12'h24C};
        logic [31:0] r;
        logic e;
        rc(12'h1CC, CTRL_RESET);
        rc(12'h27C, CTRL_RESET);
        foreach (b[i]) wr(b[i], 32'hA5C3_0F00 + 32'(i));
        foreach (b[i]) rc(b[i], 32'hA5C3_0F00 + 32'(i));
        wr(12'h1CC, 32'hFFFFFFFF);
        rc(12'h1CC, DCTRL_WMASK);
        wr(12'h27C, 32'hFFFFFFFF);
        rc(12'h27C, RCTRL_WMASK);
        wr(12'h1CC, 32'h0);
        wr(12'h27C, 32'h0);
        apb(1'b0, 12'h100, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
    endtask
    task automatic t_data;
        wr(12'h144, 32'h1000);
        wr(12'h184, 32'h2000);
        wr(12'h1C4, 32'h00080007);
        core.memOp(1'b1, 3'd2, 32'h2000);
        chkHit(1'b0);
        core.memOp(1'b0, 3'd3, 32'h2000);
        chkHit(1'b0);
        core.memOp(1'b1, 3'd3, 32'h2000);
        chkHit(1'b1);
        rc(12'h054, {14'h0, 2'd1, 8'd3, 5'h0, CAUSE_DATA});
        rc(12'h058, 32'h2000);
        wr(12'h1C4, 32'h00080005);
        core.memOp(1'b1, 3'd3, 32'h2000);
        chkHit(1'b0);
        wr(12'h140, 32'h2000);
        wr(12'h180, 32'h2000);
        wr(12'h1C0, 32'h00080005);
        wr(12'h1C4, 32'h00080007);
        core.memOp(1'b1, 3'd3, 32'h2000);
        rc(12'h054, {14'h0, 2'd0, 8'd3, 5'h0, CAUSE_DATA});
        wr(12'h1C0, 32'h00080003);
        core.memOp(1'b0, 3'd3, 32'h2000);
        chkHit(1'b1);
    endtask
    task automatic t_res;
        wr(12'h208, 32'hFF);
        wr(12'h248, 32'h42);
        wr(12'h278, 32'h10001);
        core.resOp(3'd1, 32'h12345642);
        chkHit(1'b0);
        core.resOp(3'd0, 32'h12345642);
        chkHit(1'b1);
        rc(12'h054, {14'h0, 2'd2, 8'd0, 5'h0, CAUSE_RES});
        rc(12'h058, 32'h12345642);
        wr(12'h278, 32'h00010003);
        core.resOp(3'd0, 32'h12345643);
        chkHit(1'b1);
        core.resOp(3'd0, 32'h12345642);
        chkHit(1'b0);
    endtask
    task automatic t_irq;
        chk({31'h0, irq}, 32'h0);
        rc(12'h280, 32'h3);
        wr(12'h284, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(12'h280, 32'h1);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic t_reset;
        wr(12'h1C4, 32'h00080007);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rc(12'h1C4, CTRL_RESET);
        rc(12'h054, 32'h00000000);
        chk({31'h0, irq}, 32'h0);
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_regs;
        t_data;
        t_res;
        t_irq;
        t_reset;
        give_verdict;
    end
endmodule
